// *** shared/sbr_pkg.sv ***
// constants, enumerations and timing figures shared by both bus ends
// assumes a single 20 MHz reference clock on each end
package sbr_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int PREFIX_W = 5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // slave addresses, 7-bit form
    localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 7'h2E; // 0101110b
    localparam logic [ADDR_W-1:0] ADDR_STRAP0 = 7'h2C; // 0101100b, select low
    localparam logic [ADDR_W-1:0] ADDR_STRAP1 = 7'h2D; // 0101101b, select high
    localparam logic [ADDR_W-1:0] ADDR_ARA = 7'h0C; // 0001100b
    localparam logic [ADDR_W-1:0] ADDR_GCALL = 7'h00; // general call, never matched
    localparam logic [BYTE_W-1:0] UNDEF_DATA = 8'h00;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int TIMEOUT_MS = 25;
    localparam int RESET_MAX_MS = 35;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SCL_HZ = 100_000;
    localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_HZ);
    localparam logic [1:0] STRAP_SETTLE = 2'h3; // third edge: both sync stages hold the pin
    localparam logic [1:0] SYNC_RESET = 2'h3;

    typedef enum logic [1:0] {SBR_WRITE, SBR_READ, SBR_ARA} sbr_kind_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INDEX, ST_DATA, ST_ACK, ST_TX, ST_WAIT_STOP, ST_IGNORE
    } sbr_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_RSTART, H_STOP} sbr_host_state_t;
endpackage

// *** shared/sbr_if.sv ***
// two-wire bus between the register target and the bus master
// open-drain: a party pulls a line low while its enable is high
`timescale 1ns/1ps
interface sbr_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups; only the host ever pulls the clock
    assign scl = ~host_scl_oe;
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                  output host_sda_o, output host_sda_oe);
endinterface

// *** verilog/sbr_line_mon.sv ***
// synchronises the two bus lines and finds clock edges, start and stop
// assumes both lines idle high; they come from pins, so two flops first
`timescale 1ns/1ps
module sbr_line_mon (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda,
    output logic scl_s,
    output logic sda_s,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_det,
    output logic stop_det
);
    import sbr_pkg::*;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;

    // two-flop synchronisers, then one more stage for edge detection
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync <= SYNC_RESET;
            sda_sync <= SYNC_RESET;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign scl_rise = scl_sync[1] & ~scl_prev;
    assign scl_fall = ~scl_sync[1] & scl_prev;
    // data moving while the clock stays high marks start or stop
    assign start_det = scl_sync[1] & scl_prev & ~sda_sync[1] & sda_prev;
    assign stop_det = scl_sync[1] & scl_prev & sda_sync[1] & ~sda_prev;
endmodule

// *** verilog/sbr_device.sv ***
// register target end: byte write and byte read over the two-wire bus
// assumes an outside register file answering reg_index combinationally,
// and an outside interrupt block owning alert_int_enable
`timescale 1ns/1ps

module sbr_device #(
    parameter int unsigned TIMEOUT_CYC = sbr_pkg::TIMEOUT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    sbr_if.dev bus,
    input wire logic addr_en_b,
    input wire logic addr_sel,
    input wire logic alert_int_enable,
    input wire logic alert_pending,
    input wire logic [sbr_pkg::BYTE_W-1:0] reg_rdata,
    input wire logic reg_defined,
    output logic [sbr_pkg::BYTE_W-1:0] reg_index,
    output logic [sbr_pkg::BYTE_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic alert_clear,
    output logic [sbr_pkg::ADDR_W-1:0] slave_addr
);
    import sbr_pkg::*;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [1:0] en_sync;
    logic [1:0] sel_sync;
    logic [1:0] strap_cnt;
    logic strap_mode;
    logic addr_locked;
    logic lock_sel;
    sbr_dev_state_t state;
    sbr_dev_state_t ack_next;
    logic [BYTE_W-1:0] shreg;
    logic [3:0] bitcnt;
    logic have_index;
    logic ara_sel;
    logic sda_oe;
    logic [19:0] low_cnt;
    logic timeout;
    logic [ADDR_W-1:0] next_addr;
    logic [BYTE_W-1:0] tx_byte;

    // own address from strap mode, latch state and live select level
    function automatic logic [ADDR_W-1:0] own_addr(input logic strap, input logic locked,
                                                   input logic held, input logic live);
        logic sel;
        sel = locked ? held : live;
        if (!strap) begin
            own_addr = ADDR_DEFAULT;
        end else begin
            own_addr = sel ? ADDR_STRAP1 : ADDR_STRAP0;
        end
    endfunction

    sbr_line_mon u_mon (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scl(bus.scl),
        .sda(bus.sda),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // strap pins are asynchronous levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_sync <= SYNC_RESET;
            sel_sync <= 2'h0;
        end else begin
            en_sync <= {en_sync[0], addr_en_b};
            sel_sync <= {sel_sync[0], addr_sel};
        end
    end

    // mode is caught once, after the synchronisers have filled past reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
            strap_mode <= 1'b0;
        end else if (strap_cnt != STRAP_SETTLE) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt + 2'h1 == STRAP_SETTLE) begin
                strap_mode <= ~en_sync[1];
            end
        end
    end

    // the select level is frozen at the first acknowledged own address,
    // so a later glitch on the strap cannot move the device
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_locked <= 1'b0;
            lock_sel <= 1'b0;
        end else if (strap_mode && !addr_locked && state == ST_ACK && scl_fall && !ara_sel) begin
            addr_locked <= 1'b1;
            lock_sel <= slave_addr[0];
        end
    end

    assign next_addr = own_addr(strap_mode, addr_locked, lock_sel, sel_sync[1]);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slave_addr <= ADDR_DEFAULT;
        end else begin
            slave_addr <= next_addr;
        end
    end

    // clock-low watchdog; idle and ignored states do not count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 20'h0;
        end else if (scl_s || state == ST_IDLE || state == ST_IGNORE) begin
            low_cnt <= 20'h0;
        end else if (!timeout) begin
            low_cnt <= low_cnt + 20'h1;
        end
    end

    assign timeout = (low_cnt == 20'(TIMEOUT_CYC - 1));

    // byte returned on a read: own address for alert, zero if undefined
    assign tx_byte = ara_sel ? {slave_addr, 1'b0}
                             : (reg_defined ? reg_rdata : UNDEF_DATA);

    // protocol engine: bit shifting, acknowledge and transmit
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            ack_next <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            have_index <= 1'b0;
            ara_sel <= 1'b0;
            sda_oe <= 1'b0;
            reg_index <= 8'h00;
            reg_wdata <= 8'h00;
        end else if (timeout) begin
            state <= ST_IGNORE; // release and wait for a new start
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE; // also covers start followed by stop
            sda_oe <= 1'b0;
            have_index <= 1'b0;
        end else if (start_det) begin
            // a repeated start is a read only right after an acked index;
            // its own clock rise has already counted one bit by then
            have_index <= (state == ST_DATA && bitcnt == 4'h1);
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_INDEX, ST_DATA: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s}; // msb first
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
                        if (state == ST_ADDR) begin
                            if (shreg[7:1] == slave_addr && !shreg[0]
                                && shreg[7:3] == slave_addr[6:2]) begin
                                sda_oe <= 1'b1;
                                ara_sel <= 1'b0;
                                ack_next <= ST_INDEX;
                                state <= ST_ACK;
                            end else if (shreg[7:1] == slave_addr && shreg[0] && have_index) begin
                                sda_oe <= 1'b1;
                                ara_sel <= 1'b0;
                                ack_next <= ST_TX;
                                state <= ST_ACK;
                            end else if (shreg[7:1] == ADDR_ARA && shreg[0]
                                         && alert_int_enable && alert_pending) begin
                                sda_oe <= 1'b1;
                                ara_sel <= 1'b1;
                                ack_next <= ST_TX;
                                state <= ST_ACK;
                            end else begin
                                // general call, foreign address, bare read: silent
                                state <= ST_IGNORE;
                            end
                        end else if (state == ST_INDEX) begin
                            reg_index <= shreg; // no auto increment
                            sda_oe <= 1'b1;
                            ack_next <= ST_DATA;
                            state <= ST_ACK;
                        end else begin
                            reg_wdata <= shreg;
                            sda_oe <= 1'b1;
                            ack_next <= ST_WAIT_STOP;
                            state <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        state <= ack_next;
                        if (ack_next == ST_TX) begin
                            sda_oe <= ~tx_byte[7];
                            shreg <= {tx_byte[6:0], 1'b0};
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt == BITS_PER_BYTE) begin
                            // one byte only, whatever the master answers
                            sda_oe <= 1'b0;
                            state <= ST_IGNORE;
                        end else begin
                            sda_oe <= ~shreg[7];
                            shreg <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                ST_WAIT_STOP: begin
                    // the stop's clock rise is legal; a later fall means more bits
                    if (scl_fall) begin
                        state <= ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // strobes: a write commits only on the stop that ends a full write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_wr <= 1'b0;
            alert_clear <= 1'b0;
        end else begin
            reg_wr <= stop_det && !timeout && state == ST_WAIT_STOP;
            alert_clear <= !timeout && !stop_det && !start_det && state == ST_ACK
                           && scl_fall && ara_sel;
        end
    end

    // the clock pin is input only here
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = sda_oe;
endmodule

// *** verilog/sbr_host.sv ***
// bus master end: issues byte write, byte read and alert response reads
// assumes the target on the shared bus; clock made by dividing ref_clk
`timescale 1ns/1ps
module sbr_host (
    input wire logic ref_clk,
    input wire logic rst_b,
    sbr_if.host bus,
    input wire logic cmd_valid,
    input wire sbr_pkg::sbr_kind_t cmd_kind,
    input wire logic [sbr_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sbr_pkg::BYTE_W-1:0] cmd_index,
    input wire logic [sbr_pkg::BYTE_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic done,
    output logic nack_err,
    output logic [sbr_pkg::BYTE_W-1:0] rdata
);
    import sbr_pkg::*;

    logic scl_s;
    logic sda_s;
    sbr_host_state_t state;
    sbr_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] index;
    logic [BYTE_W-1:0] wdata;
    logic [BYTE_W-1:0] txb;
    logic [BYTE_W-1:0] rbuf;
    logic [1:0] fidx;
    logic [1:0] ph;
    logic [3:0] bit_i;
    logic [7:0] div_cnt;
    logic tick;
    logic scl_oe;
    logic sda_oe;

    // byte sent in each frame of a transaction
    function automatic logic [BYTE_W-1:0] frame_byte(input sbr_kind_t k, input logic [1:0] f,
            input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] i, input logic [BYTE_W-1:0] d);
        case (k)
            SBR_WRITE: frame_byte = (f == 2'h0) ? {a, 1'b0} : ((f == 2'h1) ? i : d);
            SBR_READ: frame_byte = (f == 2'h0) ? {a, 1'b0} : ((f == 2'h1) ? i : {a, 1'b1});
            default: frame_byte = {ADDR_ARA, 1'b1};
        endcase
    endfunction

    // frame that the target drives
    function automatic logic frame_rx(input sbr_kind_t k, input logic [1:0] f);
        frame_rx = (k == SBR_READ && f == 2'h3) || (k == SBR_ARA && f == 2'h1);
    endfunction

    // last frame of the transaction
    function automatic logic frame_last(input sbr_kind_t k, input logic [1:0] f);
        frame_last = (k == SBR_WRITE && f == 2'h2) || frame_rx(k, f);
    endfunction

    sbr_line_mon u_mon (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .scl(bus.scl),
        .sda(bus.sda),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(),
        .scl_fall(),
        .start_det(),
        .stop_det()
    );

    // half-period divider; stopped while idle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 8'h0;
        end else if (state == H_IDLE || tick) begin
            div_cnt <= 8'h0;
        end else begin
            div_cnt <= div_cnt + 8'h1;
        end
    end

    assign tick = (div_cnt == 8'(SCL_HALF_CYC - 1));
    assign cmd_ready = (state == H_IDLE);

    // bit sequencer; each bit is set-up, clock high, sample-and-lower
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= H_IDLE;
            kind <= SBR_WRITE;
            addr <= 7'h00;
            index <= 8'h00;
            wdata <= 8'h00;
            txb <= 8'h00;
            rbuf <= 8'h00;
            fidx <= 2'h0;
            ph <= 2'h0;
            bit_i <= 4'h0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            done <= 1'b0;
            nack_err <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (cmd_valid) begin
                        kind <= cmd_kind;
                        addr <= cmd_addr;
                        index <= cmd_index;
                        wdata <= cmd_wdata;
                        txb <= frame_byte(cmd_kind, 2'h0, cmd_addr, cmd_index, cmd_wdata);
                        fidx <= 2'h0;
                        ph <= 2'h0;
                        nack_err <= 1'b0;
                        state <= H_START;
                    end
                end
                H_START: begin
                    if (tick) begin
                        if (ph == 2'h0) begin
                            sda_oe <= 1'b1;
                            ph <= 2'h1;
                        end else begin
                            scl_oe <= 1'b1;
                            ph <= 2'h0;
                            bit_i <= 4'h0;
                            state <= H_BIT;
                        end
                    end
                end
                H_BIT: begin
                    if (tick && ph == 2'h0) begin
                        // receive frames and every ack slot release the line (nack)
                        sda_oe <= !frame_rx(kind, fidx) && bit_i != BITS_PER_BYTE
                                  && !txb[3'(7 - bit_i)];
                        ph <= 2'h1;
                    end else if (tick && ph == 2'h1) begin
                        scl_oe <= 1'b0;
                        ph <= 2'h2;
                    end else if (tick && scl_s) begin
                        // waiting on scl_s lets another agent stretch the clock
                        scl_oe <= 1'b1;
                        ph <= 2'h0;
                        if (bit_i != BITS_PER_BYTE) begin
                            rbuf <= {rbuf[6:0], sda_s};
                            bit_i <= bit_i + 4'h1;
                        end else if (!frame_rx(kind, fidx) && sda_s) begin
                            nack_err <= 1'b1;
                            state <= H_STOP;
                        end else if (frame_last(kind, fidx)) begin
                            state <= H_STOP;
                        end else begin
                            fidx <= fidx + 2'h1;
                            txb <= frame_byte(kind, fidx + 2'h1, addr, index, wdata);
                            bit_i <= 4'h0;
                            if (kind == SBR_READ && fidx == 2'h1) begin
                                state <= H_RSTART;
                            end
                        end
                    end
                end
                H_RSTART: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        case (ph)
                            2'h0: sda_oe <= 1'b0;
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b1;
                            default: begin
                                scl_oe <= 1'b1;
                                state <= H_BIT;
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        ph <= ph + 2'h1;
                        if (ph == 2'h0) begin
                            sda_oe <= 1'b1;
                        end else if (ph == 2'h1) begin
                            scl_oe <= 1'b0;
                        end else begin
                            sda_oe <= 1'b0;
                            ph <= 2'h0;
                            rdata <= rbuf;
                            done <= 1'b1;
                            state <= H_IDLE;
                        end
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_oe;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_oe;
endmodule

// *** tb/sbr_chk.sv ***
// bus-level checks on the link between the host end and the target end
// assumes it sits beside the interface instance, on the same clock and reset
`timescale 1ns/1ps
module sbr_chk #(
    parameter int unsigned TIMEOUT_CYC = 2000
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [31:0] low_cnt;
    // length of the current clock low, for the stuck-bus abort
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= scl ? 32'h0 : low_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_clock_host_only: assert property (
        scl == !host_scl_oe) else $error("clock driven by target");
    chk_sda_wired_and: assert property (
        sda == !(host_sda_oe || dev_sda_oe)) else $error("data line level wrong");
    chk_shift_low: assert property (
        $changed(dev_sda_oe) |-> !scl && !$past(scl, 3)) else $error("target moved data late");
    chk_start_quiet: assert property (
        $fell(sda) && scl |=> !dev_sda_oe [*8]) else $error("target drove after start");
    chk_stop_quiet: assert property (
        $rose(sda) && scl |=> !dev_sda_oe [*8]) else $error("target drove after stop");
    chk_timeout_free: assert property (
        low_cnt > TIMEOUT_CYC + 8 |-> !dev_sda_oe) else $error("target held bus past timeout");
    chk_reset_idle: assert property (
        $rose(rst_b) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe) else $error("bus not free");
    chk_bit_held: assert property (
        $rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:400] scl)) else $error("bit dropped");
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
    cover property ($rose(dev_sda_oe));
endmodule

// *** tb/tb_smbus_byte_register_slave.sv ***
// bench joining host end and target end; a small register file stands outside
// assumes 20 MHz ref_clk; select strap moves only after the address has latched
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_smbus_byte_register_slave;
    import sbr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    sbr_kind_t cmd_kind = SBR_WRITE;
    logic [ADDR_W-1:0] cmd_addr = 7'h00;
    logic [BYTE_W-1:0] cmd_index = 8'h00, cmd_wdata = 8'h00;
    logic cmd_ready, done, nack_err, reg_wr, alert_clear, reg_defined;
    logic [BYTE_W-1:0] rdata, reg_index, reg_wdata, reg_rdata;
    logic [ADDR_W-1:0] slave_addr;
    logic addr_en_b = 1'b1, addr_sel = 1'b0, alert_int_enable = 1'b0, alert_pending = 1'b0;
    logic [BYTE_W-1:0] regs [16];
    int failures = 0, checked = 0;
    sbr_if bus ();
    always #25 ref_clk = ~ref_clk;
    // unknown indexes answer ff here, so a zero reply must come from the target
    assign reg_defined = (reg_index < 8'h10);
    assign reg_rdata = reg_defined ? regs[reg_index[3:0]] : 8'hFF;
    always @(posedge ref_clk) begin
        if (reg_wr && reg_defined) regs[reg_index[3:0]] <= reg_wdata;
        if (alert_clear) alert_int_enable <= 1'b0;
    end
    sbr_device #(.TIMEOUT_CYC(2000)) u_sbr_device (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus),
        .addr_en_b(addr_en_b), .addr_sel(addr_sel), .alert_int_enable(alert_int_enable),
        .alert_pending(alert_pending), .reg_rdata(reg_rdata), .reg_defined(reg_defined),
        .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .alert_clear(alert_clear), .slave_addr(slave_addr));
    sbr_host u_sbr_host (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .done(done), .nack_err(nack_err), .rdata(rdata));
    sbr_chk #(.TIMEOUT_CYC(2000)) u_sbr_chk (.ref_clk(ref_clk), .rst_b(rst_b),
        .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
    task automatic test_done();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // reset with new strap levels; straps must be steady before release
    task automatic do_reset(input logic en_b, input logic sel);
        rst_b = 1'b0;
        addr_en_b = en_b;
        addr_sel = sel;
        repeat (10) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    // one host command, then a bounded wait for its done pulse
    task automatic xfer(input sbr_kind_t k, input logic [ADDR_W-1:0] a,
                        input logic [BYTE_W-1:0] i, input logic [BYTE_W-1:0] d);
        int n;
        n = 0;
        cmd_kind = k;
        cmd_addr = a;
        cmd_index = i;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 20000) begin
            failures++;
            $display("ERROR %0t no done from host", $time);
        end
        // let the stop reach the target and its write strobe land
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        foreach (regs[k]) regs[k] = 8'h00;
        do_reset(1'b1, 1'b0);
        `CHK(slave_addr, ADDR_DEFAULT);
        `CHK(cmd_ready, 1'b1);
        xfer(SBR_WRITE, ADDR_DEFAULT, 8'h03, 8'hA5);
        `CHK(regs[3], 8'hA5);
        `CHK(regs[4], 8'h00);
        xfer(SBR_READ, ADDR_DEFAULT, 8'h03, 8'h00);
        `CHK(rdata, 8'hA5);
        $display("write and read done");
        xfer(SBR_WRITE, 7'h2F, 8'h03, 8'h11);
        `CHK(nack_err, 1'b1);
        xfer(SBR_WRITE, ADDR_GCALL, 8'h03, 8'h22);
        `CHK(nack_err, 1'b1);
        `CHK(regs[3], 8'hA5);
        xfer(SBR_READ, ADDR_DEFAULT, 8'h20, 8'h00);
        `CHK(rdata, UNDEF_DATA);
        xfer(SBR_WRITE, ADDR_DEFAULT, 8'h20, 8'h33);
        `CHK(nack_err, 1'b0);
        $display("refusals done");
        alert_pending = 1'b1;
        xfer(SBR_ARA, ADDR_ARA, 8'h00, 8'h00);
        `CHK(nack_err, 1'b1);
        alert_int_enable = 1'b1;
        xfer(SBR_ARA, ADDR_ARA, 8'h00, 8'h00);
        `CHK(rdata[7:1], ADDR_DEFAULT);
        `CHK(alert_int_enable, 1'b0);
        $display("alert done");
        do_reset(1'b0, 1'b1); // straps enabled, select pin high
        xfer(SBR_WRITE, ADDR_STRAP0, 8'h05, 8'h5A);
        `CHK(nack_err, 1'b1);
        xfer(SBR_WRITE, ADDR_STRAP1, 8'h05, 8'h5A);
        `CHK(regs[5], 8'h5A);
        addr_sel = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK(slave_addr, ADDR_STRAP1);
        $display("strap done");
        test_done();
    end
    // watchdog sized well past the expected run
    initial begin
        #(100000 * 50);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end
endmodule
